// ---- common/rotiu_pkg.sv ----
// Package for the rotate and interrupt-return unit.
// Assumes one core clock; shared by the unit and its rotator.
package rotiu_pkg;

  // ----------------------------------------
  // Operation codes from the decoder
  // ----------------------------------------
  typedef enum logic [3:0]
  {
    ROTIU_OP_NONE,
    ROTIU_OP_RETURN_FROM_INTERRUPT,
    ROTIU_OP_ROTATE_LEFT_MEM,
    ROTIU_OP_ROTATE_LEFT_TO_ACC,
    ROTIU_OP_ROTATE_LEFT_CARRY_MEM,
    ROTIU_OP_ROTATE_LEFT_CARRY_TO_ACC,
    ROTIU_OP_ROTATE_RIGHT_MEM,
    ROTIU_OP_ROTATE_RIGHT_TO_ACC,
    ROTIU_OP_ROTATE_RIGHT_CARRY_MEM
  } rotiu_op_t;

  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int ROTIU_DATA_W = 8;
  localparam int ROTIU_PC_W = 13;
  localparam int ROTIU_SP_W = 4;
  localparam logic ROTIU_MIE_SET = 1'b1;
  localparam logic ROTIU_MIE_RESET = 1'b0;
  localparam logic ROTIU_CARRY_RESET = 1'b0;
  localparam logic [7:0] ROTIU_ACC_RESET = 8'h00;
  localparam int ROTIU_MSB = 7;
  localparam int ROTIU_LSB = 0;

endpackage : rotiu_pkg

// ---- rtl/rotiu_rotator.sv ----
// Combinational one-place byte rotator, with or without carry.
// Assumes the caller chooses which result and carry to keep.
module rotiu_rotator
(
  input wire logic [7:0] data_in,     // Byte to rotate
  input wire logic carry_in,          // Old carry flag
  input wire logic dir_right,         // 1 rotates right
  input wire logic through_carry,     // 1 rotates through carry
  output logic [7:0] data_out,        // Rotated byte
  output logic carry_out              // Bit shifted out
);

  wire logic left_fill;
  wire logic right_fill;

  // RL3 RL4 plain wrap, RL5 RL6 carry fill
  assign left_fill = through_carry ? carry_in : data_in[rotiu_pkg::ROTIU_MSB];
  // RL7 RL8 plain wrap, RL9 carry fill
  assign right_fill = through_carry ? carry_in : data_in[rotiu_pkg::ROTIU_LSB];
  assign data_out = dir_right ? {right_fill, data_in[7:1]} : {data_in[6:0], left_fill};
  assign carry_out = dir_right ? data_in[rotiu_pkg::ROTIU_LSB]
                               : data_in[rotiu_pkg::ROTIU_MSB];

endmodule : rotiu_rotator

// ---- rtl/rotiu_unit.sv ----
// Rotate and interrupt-return execution slice of an 8-bit core.
// Assumes the decoder pulses op_valid once per instruction, memory reads
// are presented combinationally in the same cycle, and the stack holds
// return addresses the core pushed earlier.

// Summary of operation
// RL1 - Interrupt return reloads PC from stack top, sets interrupt enable, keeps flags.
// RL2 - Pending interrupt at interrupt return is taken before main program resumes.
// RL3 - Rotate left memory: bit 7 into bit 0, written back, no flags.
// RL4 - Rotate left to accumulator: memory untouched, no flags changed.
// RL5 - Rotate left through carry: carry into bit 0, bit 7 to carry.
// RL6 - Same nine-bit left rotation, result into accumulator, carry updated.
// RL7 - Rotate right memory: bit 0 into bit 7, written back, no flags.
// RL8 - Rotate right to accumulator: memory untouched, no flags changed.
// RL9 - Rotate right through carry: carry into bit 7, bit 0 to carry.
// RL10 - Interrupt return pops the stack pointer like a plain return.
module rotiu_unit
#(
  parameter int PC_W = rotiu_pkg::ROTIU_PC_W,
  parameter int SP_W = rotiu_pkg::ROTIU_SP_W
)
(
  input wire logic core_clk,                  // Core clock, 50 MHz
  input wire logic reset,                     // Synchronous reset, active high
  input wire logic op_valid,                  // One-cycle instruction strobe
  input wire rotiu_pkg::rotiu_op_t op_code,   // Decoded operation
  input wire logic [7:0] mem_rdata,           // Addressed memory byte
  input wire logic [PC_W-1:0] stack_top,      // Top return address
  input wire logic int_pending,               // Interrupt request waiting
  input wire logic int_taken,                 // Core entered an interrupt
  output logic [7:0] mem_wdata,               // Byte to write back
  output logic mem_we,                        // Memory write strobe
  output logic [7:0] acc_q,                   // Accumulator
  output logic carry_q,                       // Carry flag
  output logic master_interrupt_enable_q,     // Global interrupt enable
  output logic pc_load,                       // Program counter load strobe
  output logic [PC_W-1:0] pc_load_value,      // New program counter
  output logic stack_pop,                     // Release stack entry
  output logic [SP_W-1:0] stack_ptr_q,        // Return stack pointer
  output logic int_service_req                // Take interrupt before resuming
);

  // --------------------------------------------------------
  // Decode
  // --------------------------------------------------------
  wire logic is_return_from_interrupt;
  wire logic is_right;
  wire logic is_carry;
  wire logic to_mem;
  wire logic to_acc;
  wire logic [7:0] rot_data;
  wire logic rot_carry;

  assign is_return_from_interrupt = op_valid && (op_code == rotiu_pkg::ROTIU_OP_RETURN_FROM_INTERRUPT);
  assign is_right = (op_code == rotiu_pkg::ROTIU_OP_ROTATE_RIGHT_MEM)
                 || (op_code == rotiu_pkg::ROTIU_OP_ROTATE_RIGHT_TO_ACC)
                 || (op_code == rotiu_pkg::ROTIU_OP_ROTATE_RIGHT_CARRY_MEM);
  assign is_carry = (op_code == rotiu_pkg::ROTIU_OP_ROTATE_LEFT_CARRY_MEM)
                 || (op_code == rotiu_pkg::ROTIU_OP_ROTATE_LEFT_CARRY_TO_ACC)
                 || (op_code == rotiu_pkg::ROTIU_OP_ROTATE_RIGHT_CARRY_MEM);
  assign to_mem = op_valid && ((op_code == rotiu_pkg::ROTIU_OP_ROTATE_LEFT_MEM)
                 || (op_code == rotiu_pkg::ROTIU_OP_ROTATE_LEFT_CARRY_MEM)
                 || (op_code == rotiu_pkg::ROTIU_OP_ROTATE_RIGHT_MEM)
                 || (op_code == rotiu_pkg::ROTIU_OP_ROTATE_RIGHT_CARRY_MEM));
  assign to_acc = op_valid && ((op_code == rotiu_pkg::ROTIU_OP_ROTATE_LEFT_TO_ACC)
                 || (op_code == rotiu_pkg::ROTIU_OP_ROTATE_LEFT_CARRY_TO_ACC)
                 || (op_code == rotiu_pkg::ROTIU_OP_ROTATE_RIGHT_TO_ACC));

  rotiu_rotator u_rot
  (
    .data_in(mem_rdata),
    .carry_in(carry_q),
    .dir_right(is_right),
    .through_carry(is_carry),
    .data_out(rot_data),
    .carry_out(rot_carry)
  );

  // --------------------------------------------------------
  // Datapath registers
  // --------------------------------------------------------
  logic [7:0] mem_wdata_d;
  logic mem_we_d;
  logic [7:0] acc_d;
  logic carry_d;
  logic mie_d;
  logic pc_load_d;
  logic [PC_W-1:0] pc_val_d;
  logic pop_d;
  logic push_d;
  logic [SP_W-1:0] sp_d;
  logic svc_d;

  // RL3 RL5 RL7 RL9 memory write-back
  assign mem_we_d = to_mem;
  assign mem_wdata_d = to_mem ? rot_data : mem_wdata;
  // RL4 RL6 RL8 accumulator result only
  assign acc_d = to_acc ? rot_data : acc_q;
  // RL5 RL6 RL9 only carry variants touch carry
  assign carry_d = ((to_mem || to_acc) && is_carry) ? rot_carry : carry_q;
  // RL1 enable set; taking an interrupt clears it unless a return is in the same cycle
  assign mie_d = is_return_from_interrupt ? rotiu_pkg::ROTIU_MIE_SET
               : (int_taken ? rotiu_pkg::ROTIU_MIE_RESET : master_interrupt_enable_q);
  // RL1 program counter from stack top
  assign pc_load_d = is_return_from_interrupt;
  assign pc_val_d = is_return_from_interrupt ? stack_top : pc_load_value;
  // RL10 release popped entry
  assign pop_d = is_return_from_interrupt && (stack_ptr_q != '0);
  // Entering an interrupt pushes unless the stack is full; a return in the same cycle wins, so no push
  assign push_d = int_taken && !is_return_from_interrupt && (stack_ptr_q != '1);
  assign sp_d = pop_d ? stack_ptr_q - SP_W'(1)
              : (push_d ? stack_ptr_q + SP_W'(1) : stack_ptr_q);
  // RL2 pending interrupt served before main program
  assign svc_d = is_return_from_interrupt && int_pending;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      mem_wdata <= 8'h00;
      mem_we <= 1'b0;
      acc_q <= rotiu_pkg::ROTIU_ACC_RESET;
      carry_q <= rotiu_pkg::ROTIU_CARRY_RESET;
      master_interrupt_enable_q <= rotiu_pkg::ROTIU_MIE_RESET;
      pc_load <= 1'b0;
      pc_load_value <= '0;
      stack_pop <= 1'b0;
      stack_ptr_q <= '0;
      int_service_req <= 1'b0;
    end
    else
    begin
      mem_wdata <= mem_wdata_d;
      mem_we <= mem_we_d;
      acc_q <= acc_d;
      carry_q <= carry_d;
      master_interrupt_enable_q <= mie_d;
      pc_load <= pc_load_d;
      pc_load_value <= pc_val_d;
      stack_pop <= pop_d;
      stack_ptr_q <= sp_d;
      int_service_req <= svc_d;
    end
  end

  // Stack depth is tracked here by pushes the core reports via int_taken
  // only; call pushes belong to the plain return logic elsewhere.

  // --------------------------------------------------------
  // Checks
  // --------------------------------------------------------
  sequence s_return_from_interrupt_issued;
    op_valid && op_code == rotiu_pkg::ROTIU_OP_RETURN_FROM_INTERRUPT;
  endsequence

  chk_return_from_interrupt_pc_load: assert property (@(posedge core_clk) disable iff (reset) // RL1
    s_return_from_interrupt_issued |=> pc_load && pc_load_value == $past(stack_top)
                      && master_interrupt_enable_q)
    else $error("interrupt return did not reload pc or set enable");

  chk_return_from_interrupt_flags_kept: assert property (@(posedge core_clk) disable iff (reset) // RL1
    s_return_from_interrupt_issued |=> $stable(carry_q) && $stable(acc_q) && !mem_we)
    else $error("interrupt return altered flags or data");

  chk_pending_served: assert property (@(posedge core_clk) disable iff (reset) // RL2
    (s_return_from_interrupt_issued and int_pending) |=> int_service_req)
    else $error("pending interrupt not flagged at interrupt return");

  chk_rotl_mem: assert property (@(posedge core_clk) disable iff (reset) // RL3
    op_valid && op_code == rotiu_pkg::ROTIU_OP_ROTATE_LEFT_MEM |=>
      mem_we && mem_wdata == {$past(mem_rdata[6:0]), $past(mem_rdata[7])} && $stable(carry_q))
    else $error("rotate left memory result wrong");

  chk_rotl_acc: assert property (@(posedge core_clk) disable iff (reset) // RL4
    op_valid && op_code == rotiu_pkg::ROTIU_OP_ROTATE_LEFT_TO_ACC |=>
      !mem_we && acc_q == {$past(mem_rdata[6:0]), $past(mem_rdata[7])} && $stable(carry_q))
    else $error("rotate left to accumulator wrong");

  chk_rotlc_mem: assert property (@(posedge core_clk) disable iff (reset) // RL5
    op_valid && op_code == rotiu_pkg::ROTIU_OP_ROTATE_LEFT_CARRY_MEM |=>
      mem_we && mem_wdata == {$past(mem_rdata[6:0]), $past(carry_q)}
      && carry_q == $past(mem_rdata[7]))
    else $error("rotate left through carry memory wrong");

  chk_rotlc_acc: assert property (@(posedge core_clk) disable iff (reset) // RL6
    op_valid && op_code == rotiu_pkg::ROTIU_OP_ROTATE_LEFT_CARRY_TO_ACC |=>
      !mem_we && acc_q == {$past(mem_rdata[6:0]), $past(carry_q)}
      && carry_q == $past(mem_rdata[7]))
    else $error("rotate left through carry to accumulator wrong");

  chk_rotr_mem: assert property (@(posedge core_clk) disable iff (reset) // RL7
    op_valid && op_code == rotiu_pkg::ROTIU_OP_ROTATE_RIGHT_MEM |=>
      mem_we && mem_wdata == {$past(mem_rdata[0]), $past(mem_rdata[7:1])} && $stable(carry_q))
    else $error("rotate right memory result wrong");

  chk_rotr_acc: assert property (@(posedge core_clk) disable iff (reset) // RL8
    op_valid && op_code == rotiu_pkg::ROTIU_OP_ROTATE_RIGHT_TO_ACC |=>
      !mem_we && acc_q == {$past(mem_rdata[0]), $past(mem_rdata[7:1])} && $stable(carry_q))
    else $error("rotate right to accumulator wrong");

  chk_rotrc_mem: assert property (@(posedge core_clk) disable iff (reset) // RL9
    op_valid && op_code == rotiu_pkg::ROTIU_OP_ROTATE_RIGHT_CARRY_MEM |=>
      mem_we && mem_wdata == {$past(carry_q), $past(mem_rdata[7:1])}
      && carry_q == $past(mem_rdata[0]))
    else $error("rotate right through carry memory wrong");

  chk_stack_pop: assert property (@(posedge core_clk) disable iff (reset) // RL10
    (s_return_from_interrupt_issued and stack_ptr_q != '0) |=>
      stack_pop && stack_ptr_q == $past(stack_ptr_q) - 1)
    else $error("interrupt return did not pop the stack");

  chk_stack_push: assert property (@(posedge core_clk) disable iff (reset) // RL10
    !(op_valid && op_code == rotiu_pkg::ROTIU_OP_RETURN_FROM_INTERRUPT) && int_taken
      && stack_ptr_q != '1 |=> !stack_pop && stack_ptr_q == $past(stack_ptr_q) + 1)
    else $error("interrupt entry did not push the stack");

endmodule : rotiu_unit

// ---- bench/rotate_and_interrupt_return_unit_test.sv ----
// Self-checking bench for the rotate and interrupt-return unit.
// Assumes the unit's one-cycle answer; inputs change on the falling edge.
module rotate_and_interrupt_return_unit_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic op_valid = 1'b0;
  rotiu_pkg::rotiu_op_t op_code = rotiu_pkg::ROTIU_OP_NONE;
  logic [7:0] mem_rdata = 8'h00;
  logic [12:0] stack_top = 13'h0000;
  logic int_pending = 1'b0;
  logic int_taken = 1'b0;
  logic [7:0] mem_wdata, acc_q;
  logic mem_we, carry_q, master_interrupt_enable_q, pc_load, stack_pop, int_service_req;
  logic [12:0] pc_load_value;
  logic [3:0] stack_ptr_q;
  int err_count = 0;
  int checks_done = 0;
  int seed = 11859;
  int r;
  logic [7:0] exp_acc = 8'h00;
  logic exp_c = 1'b0;
  logic exp_mie = 1'b0;
  logic [3:0] exp_sp = 4'h0;
  rotiu_unit dut (.core_clk(core_clk), .reset(reset), .op_valid(op_valid), .op_code(op_code),
    .mem_rdata(mem_rdata), .stack_top(stack_top), .int_pending(int_pending),
    .int_taken(int_taken), .mem_wdata(mem_wdata), .mem_we(mem_we), .acc_q(acc_q),
    .carry_q(carry_q), .master_interrupt_enable_q(master_interrupt_enable_q),
    .pc_load(pc_load), .pc_load_value(pc_load_value), .stack_pop(stack_pop),
    .stack_ptr_q(stack_ptr_q), .int_service_req(int_service_req));
  initial
  begin
    forever #10 core_clk = ~core_clk;
  end
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // Returns {to_memory, new_carry, result byte}
  function automatic logic [9:0] model(input rotiu_pkg::rotiu_op_t op, input logic [7:0] d,
    input logic c);
    case (op)
      rotiu_pkg::ROTIU_OP_ROTATE_LEFT_MEM: return {1'b1, c, d[6:0], d[7]};
      rotiu_pkg::ROTIU_OP_ROTATE_LEFT_TO_ACC: return {1'b0, c, d[6:0], d[7]};
      rotiu_pkg::ROTIU_OP_ROTATE_LEFT_CARRY_MEM: return {1'b1, d[7], d[6:0], c};
      rotiu_pkg::ROTIU_OP_ROTATE_LEFT_CARRY_TO_ACC: return {1'b0, d[7], d[6:0], c};
      rotiu_pkg::ROTIU_OP_ROTATE_RIGHT_MEM: return {1'b1, c, d[0], d[7:1]};
      rotiu_pkg::ROTIU_OP_ROTATE_RIGHT_TO_ACC: return {1'b0, c, d[0], d[7:1]};
      rotiu_pkg::ROTIU_OP_ROTATE_RIGHT_CARRY_MEM: return {1'b1, d[0], c, d[7:1]};
      default: return {2'h0, 8'h00};
    endcase
  endfunction : model
  // Called at a falling edge; leaves op_valid high so ops may run back to back
  task automatic run_op(input rotiu_pkg::rotiu_op_t op, input logic [7:0] d,
    input logic [12:0] top, input logic pend);
    logic [9:0] m;
    logic is_ret;
    logic is_rot;
    logic is_pop;
    logic is_push;
    m = model(op, d, exp_c);
    is_ret = (op == rotiu_pkg::ROTIU_OP_RETURN_FROM_INTERRUPT);
    is_rot = (op != rotiu_pkg::ROTIU_OP_NONE) && !is_ret;
    // Return pops only when something is stacked; entry pushes unless full or returning
    is_pop = is_ret && (exp_sp != 4'h0);
    is_push = int_taken && !is_ret && (exp_sp != 4'hF);
    op_valid = 1'b1;
    op_code = op;
    mem_rdata = d;
    stack_top = top;
    int_pending = pend;
    @(negedge core_clk);
    mem_rdata = ~d;
    if (is_rot)
    begin
      exp_c = m[8];
      if (!m[9])
        exp_acc = m[7:0];
      if (m[9])
        chk("mem_wdata", {8'h00, mem_wdata}, {8'h00, m[7:0]});
    end
    if (is_ret)
      exp_mie = 1'b1;
    else if (int_taken)
      exp_mie = 1'b0;
    if (is_pop)
      exp_sp = exp_sp - 4'h1;
    else if (is_push)
      exp_sp = exp_sp + 4'h1;
    chk("mem_we", {15'h0000, mem_we}, {15'h0000, is_rot & m[9]});
    chk("acc_q", {8'h00, acc_q}, {8'h00, exp_acc});
    chk("carry_q", {15'h0000, carry_q}, {15'h0000, exp_c});
    chk("mie", {15'h0000, master_interrupt_enable_q}, {15'h0000, exp_mie});
    chk("pc_load", {15'h0000, pc_load}, {15'h0000, is_ret});
    if (is_ret)
      chk("pc_load_value", {3'h0, pc_load_value}, {3'h0, top});
    chk("int_service_req", {15'h0000, int_service_req}, {15'h0000, is_ret & pend});
    chk("stack_pop", {15'h0000, stack_pop}, {15'h0000, is_pop});
    chk("stack_ptr_q", {12'h000, stack_ptr_q}, {12'h000, exp_sp});
  endtask : run_op
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  initial
  begin
    #(20 * 5000);
    err_count++;
    close_out();
  end
  initial
  begin
    repeat (6) @(negedge core_clk);
    reset = 1'b0;
    chk("reset_acc", {8'h00, acc_q}, 16'h0000);
    chk("reset_mie", {15'h0000, master_interrupt_enable_q}, 16'h0000);
    // --------------------------------
    // Corner cases
    // --------------------------------
    run_op(rotiu_pkg::ROTIU_OP_ROTATE_LEFT_MEM, 8'h81, 13'h0000, 1'b0);
    run_op(rotiu_pkg::ROTIU_OP_ROTATE_LEFT_CARRY_MEM, 8'h80, 13'h0000, 1'b0);
    run_op(rotiu_pkg::ROTIU_OP_ROTATE_LEFT_CARRY_TO_ACC, 8'h80, 13'h0000, 1'b0);
    run_op(rotiu_pkg::ROTIU_OP_ROTATE_RIGHT_CARRY_MEM, 8'h01, 13'h0000, 1'b0);
    run_op(rotiu_pkg::ROTIU_OP_ROTATE_RIGHT_TO_ACC, 8'h01, 13'h0000, 1'b0);
    run_op(rotiu_pkg::ROTIU_OP_RETURN_FROM_INTERRUPT, 8'h00, 13'h1FFF, 1'b1);
    op_valid = 1'b0;
    int_taken = 1'b1;
    @(negedge core_clk);
    int_taken = 1'b0;
    exp_mie = 1'b0;
    exp_sp = 4'h1;
    chk("mie_cleared", {15'h0000, master_interrupt_enable_q}, 16'h0000);
    chk("sp_pushed", {12'h000, stack_ptr_q}, 16'h0001);
    run_op(rotiu_pkg::ROTIU_OP_RETURN_FROM_INTERRUPT, 8'h00, 13'h0ABC, 1'b0);
    $display("corner tests done");
    // --------------------------------
    // Random back-to-back operations
    // --------------------------------
    repeat (400)
    begin
      r = ($random(seed) & 32'h7FFF_FFFF) % 9;
      int_taken = (($random(seed) & 32'h0000_0003) == 0);
      run_op(rotiu_pkg::rotiu_op_t'(r[3:0]), 8'($random(seed)), 13'($random(seed)),
        1'($random(seed)));
    end
    op_valid = 1'b0;
    int_taken = 1'b0;
    $display("random tests done");
    close_out();
  end
endmodule : rotate_and_interrupt_return_unit_test
